// ===== verilog/anab_pkg.sv
// auto-negotiation ability register bank: constants and types
// assumes a management frame decoder on the same clock drives the reg port
package anab_pkg;

    localparam int REG_AW = 5;
    localparam int REG_DW = 16;

    // register addresses on the management interface
    localparam logic [REG_AW-1:0] ADDR_LOCAL_ADVERTISE = 5'h04;
    localparam logic [REG_AW-1:0] ADDR_PARTNER_BASE_PAGE = 5'h05;

    // field positions shared by both registers
    localparam int BIT_NEXT_PAGE = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_REMOTE_FAULT = 13;
    localparam int BIT_RSVD_HI = 12;
    localparam int BIT_RSVD_LO = 11;
    localparam int BIT_PAUSE = 10;
    localparam int BIT_T4 = 9;
    localparam int BIT_TX_FD = 8;
    localparam int BIT_TX_HD = 7;
    localparam int BIT_T_FD = 6;
    localparam int BIT_T_HD = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 0;

    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [REG_DW-1:0] ZERO_WORD = 16'h0000;

    // advertisement reset value without the strap-driven bits 8 and 6
    localparam logic [REG_DW-1:0] ADV_RESET = 16'h00a1;
    // bits software may write in the advertisement register
    localparam logic [REG_DW-1:0] ADV_WR_MASK = 16'hbde0;
    // consistency compare ignores the acknowledge bit
    localparam logic [REG_DW-1:0] CONSIST_MASK = 16'hbfff;

    // consistent bursts needed before acknowledging
    localparam int ACK_BURSTS = 3;
    // cycles after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        ANAB_IDLE = 2'b00,
        ANAB_SEEN1 = 2'b01,
        ANAB_SEEN2 = 2'b10,
        ANAB_ACKED = 2'b11
    } anab_ack_state_t;

    typedef struct packed {
        logic next_page;
        logic ack;
        logic remote_fault;
        logic [1:0] reserved;
        logic pause;
        logic t4;
        logic tx_fd;
        logic tx_hd;
        logic t_fd;
        logic t_hd;
        logic [4:0] selector;
    } anab_page_t;

endpackage : anab_pkg

// ===== verilog/anab_regs.sv
// auto-negotiation advertisement and link partner base page registers
// assumes reg port and burst port come from logic on clk; strap is a pin
`timescale 1ns/1ps
module anab_regs (
    input wire logic clk, // core clock, 250 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic duplex_strap_pin, // duplex strap, asynchronous pin
    input wire logic reg_wr, // management write strobe
    input wire logic reg_rd, // management read strobe
    input wire logic [anab_pkg::REG_AW-1:0] reg_addr, // register address
    input wire logic [anab_pkg::REG_DW-1:0] reg_wdata, // write data
    output logic [anab_pkg::REG_DW-1:0] reg_rdata, // registered read data
    output logic reg_rvalid, // read data valid, one cycle
    output logic reg_hit, // read data came from this bank
    input wire logic burst_valid, // received burst, one-cycle pulse
    input wire logic [anab_pkg::REG_DW-1:0] burst_word, // its code word
    input wire logic an_restart, // restart negotiation, pulse
    input wire logic an_complete, // negotiation complete status
    input wire logic exp_read, // expansion register read, pulse
    output anab_pkg::anab_page_t local_page, // page to transmit
    output anab_pkg::anab_page_t partner_page, // received base page
    output logic pages_valid, // pages may be used
    output logic page_received, // latched page-received flag
    output logic strap_full_duplex // synchronised duplex strap level
);
    import anab_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // strap synchroniser and capture after reset release
    logic strap_meta;
    logic strap_sync;
    logic [1:0] settle_cnt;
    logic [1:0] next_settle_cnt;
    logic strap_loaded;
    logic next_strap_loaded;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            strap_meta <= duplex_strap_pin;
            strap_sync <= strap_meta;
        end
    end

    always_comb begin
        next_settle_cnt = settle_cnt;
        next_strap_loaded = strap_loaded;
        if (!strap_loaded) begin
            if (settle_cnt == STRAP_SETTLE) begin
                next_strap_loaded = 1'b1;
            end else begin
                next_settle_cnt = 2'(settle_cnt + 2'h1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle_cnt <= 2'h0;
            strap_loaded <= 1'b0;
        end else begin
            settle_cnt <= next_settle_cnt;
            strap_loaded <= next_strap_loaded;
        end
    end

    // true in the one cycle the strap defaults are copied in
    logic strap_take;
    assign strap_take = !strap_loaded && (settle_cnt == STRAP_SETTLE);

    ////////////////////////////////////////////////////////////////////
    // consistent-burst detection for the acknowledge bit
    function automatic logic consistent(input logic [REG_DW-1:0] a,
                                        input logic [REG_DW-1:0] b);
        consistent = ((a & CONSIST_MASK) == (b & CONSIST_MASK));
    endfunction : consistent

    anab_ack_state_t ack_state;
    anab_ack_state_t next_ack_state;
    logic [REG_DW-1:0] last_word;
    logic [REG_DW-1:0] next_last_word;
    logic load_partner;

    always_comb begin
        next_ack_state = ack_state;
        next_last_word = last_word;
        load_partner = 1'b0;
        if (an_restart) begin
            next_ack_state = ANAB_IDLE;
            next_last_word = ZERO_WORD;
        end else if (burst_valid) begin
            next_last_word = burst_word;
            case (ack_state)
                ANAB_IDLE: begin
                    next_ack_state = ANAB_SEEN1;
                end
                ANAB_SEEN1: begin
                    next_ack_state = consistent(burst_word, last_word)
                                     ? ANAB_SEEN2 : ANAB_SEEN1;
                end
                ANAB_SEEN2: begin
                    if (consistent(burst_word, last_word)) begin
                        next_ack_state = ANAB_ACKED;
                        load_partner = 1'b1;
                    end else begin
                        next_ack_state = ANAB_SEEN1;
                    end
                end
                ANAB_ACKED: begin
                    // a changed page restarts the count
                    if (!consistent(burst_word, last_word)) begin
                        next_ack_state = ANAB_SEEN1;
                    end
                end
                default: begin
                    next_ack_state = ANAB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_state <= ANAB_IDLE;
            last_word <= ZERO_WORD;
        end else begin
            ack_state <= next_ack_state;
            last_word <= next_last_word;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // advertisement register
    logic [REG_DW-1:0] adv;
    logic [REG_DW-1:0] next_adv;
    logic adv_tx_fd_written;
    logic adv_t_fd_written;
    logic next_tx_fd_written;
    logic next_t_fd_written;
    logic adv_wr;
    logic [REG_DW-1:0] adv_view;

    assign adv_wr = reg_wr && (reg_addr == ADDR_LOCAL_ADVERTISE);

    always_comb begin
        next_adv = adv;
        next_tx_fd_written = adv_tx_fd_written;
        next_t_fd_written = adv_t_fd_written;
        // bits 9, 14 and the selector are never stored from writes
        if (adv_wr) begin
            next_adv = (adv & ~ADV_WR_MASK) | (reg_wdata & ADV_WR_MASK);
            next_tx_fd_written = 1'b1;
            next_t_fd_written = 1'b1;
        end
        // strap default only where software has not written yet
        if (strap_take && !adv_wr) begin
            if (!adv_tx_fd_written) begin
                next_adv[BIT_TX_FD] = strap_sync;
            end
            if (!adv_t_fd_written) begin
                next_adv[BIT_T_FD] = strap_sync;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            adv <= ADV_RESET;
            adv_tx_fd_written <= 1'b0;
            adv_t_fd_written <= 1'b0;
        end else begin
            adv <= next_adv;
            adv_tx_fd_written <= next_tx_fd_written;
            adv_t_fd_written <= next_t_fd_written;
        end
    end

    always_comb begin
        adv_view = adv;
        adv_view[BIT_ACK] = (ack_state == ANAB_ACKED);
        adv_view[BIT_T4] = 1'b0;
        adv_view[SEL_HI:SEL_LO] = SELECTOR_8023;
    end

    ////////////////////////////////////////////////////////////////////
    // link partner register and page-received latch
    logic [REG_DW-1:0] lp;
    logic [REG_DW-1:0] next_lp;
    logic next_page_received;

    always_comb begin
        // one word loaded whole, so no mix of two pages is visible
        next_lp = load_partner ? burst_word : lp;
        // a new page wins over a clearing read in the same cycle
        if (load_partner) begin
            next_page_received = 1'b1;
        end else if (exp_read) begin
            next_page_received = 1'b0;
        end else begin
            next_page_received = page_received;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lp <= ZERO_WORD;
            page_received <= 1'b0;
        end else begin
            lp <= next_lp;
            page_received <= next_page_received;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // management read path; other addresses read zero, hit low
    logic [REG_DW-1:0] next_rdata;
    logic next_hit;

    always_comb begin
        next_rdata = ZERO_WORD;
        next_hit = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_LOCAL_ADVERTISE: begin
                    next_rdata = adv_view;
                    next_hit = 1'b1;
                end
                ADDR_PARTNER_BASE_PAGE: begin
                    next_rdata = lp;
                    next_hit = 1'b1;
                end
                default: begin
                    next_rdata = ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= ZERO_WORD;
            reg_rvalid <= 1'b0;
            reg_hit <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rvalid <= reg_rd;
            reg_hit <= next_hit;
        end
    end

    assign local_page = anab_page_t'(adv_view);
    assign partner_page = anab_page_t'(lp);
    assign pages_valid = an_complete;
    assign strap_full_duplex = strap_sync;

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_ADV_RESET: assert property (@(posedge clk)
        !rst_b |=> (adv[BIT_NEXT_PAGE] == 1'b0) && !adv[BIT_REMOTE_FAULT]
                   && !adv[BIT_PAUSE] && adv[BIT_TX_HD] && adv[BIT_T_HD])
        else $error("advertisement reset value wrong");
    // two more bursts are needed, so no ack in the next two cycles
    AST_ACK_AFTER3: assert property (@(posedge clk)
        disable iff (!rst_b)
        (ack_state == ANAB_IDLE) && burst_valid && !an_restart
        |=> !local_page.ack [*2])
        else $error("ack set too early");
    AST_ACK_MATCH: assert property (@(posedge clk)
        disable iff (!rst_b)
        $rose(local_page.ack) |-> $past(ack_state) == ANAB_SEEN2
                                  && page_received)
        else $error("ack rose without third burst");
    AST_ACK_CLEAR: assert property (@(posedge clk)
        disable iff (!rst_b)
        an_restart |=> !local_page.ack)
        else $error("ack survived a restart");
    AST_WRITE_TAKES: assert property (@(posedge clk)
        disable iff (!rst_b)
        adv_wr |=> local_page.next_page == $past(reg_wdata[BIT_NEXT_PAGE])
                   && local_page.pause == $past(reg_wdata[BIT_PAUSE])
                   && local_page.remote_fault
                      == $past(reg_wdata[BIT_REMOTE_FAULT]))
        else $error("advertisement write not stored");
    AST_T4_ZERO: assert property (@(posedge clk)
        disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_LOCAL_ADVERTISE
        |=> reg_rdata[BIT_T4] == 1'b0
            && reg_rdata[SEL_HI:SEL_LO] == SELECTOR_8023)
        else $error("constant advertisement fields wrong");
    AST_STRAP_DEFAULT: assert property (@(posedge clk)
        disable iff (!rst_b)
        strap_take && !adv_wr && !adv_tx_fd_written
        |=> adv[BIT_TX_FD] == $past(strap_sync)
            && adv[BIT_T_FD] == $past(strap_sync))
        else $error("strap default not copied");
    AST_LP_WHOLE: assert property (@(posedge clk)
        disable iff (!rst_b)
        lp != $past(lp) |-> $past(load_partner)
                           && lp == $past(burst_word))
        else $error("partner register changed without a load");
    AST_PR_SET: assert property (@(posedge clk)
        disable iff (!rst_b)
        load_partner && exp_read |=> page_received)
        else $error("page received lost to a read");
    AST_PR_CLR: assert property (@(posedge clk)
        disable iff (!rst_b)
        exp_read && !load_partner |=> !page_received)
        else $error("page received not cleared by read");
    AST_PR_RISE: assert property (@(posedge clk)
        disable iff (!rst_b)
        $rose(page_received) |-> $past(load_partner))
        else $error("page received set without a load");
    AST_VALID: assert property (@(posedge clk)
        disable iff (!rst_b)
        pages_valid == an_complete)
        else $error("validity does not follow completion");

    COV_ACK: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(local_page.ack));
    COV_READ_LP: cover property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == ADDR_PARTNER_BASE_PAGE && page_received);
    COV_SET_CLR: cover property (@(posedge clk) disable iff (!rst_b)
        load_partner && exp_read);
    COV_WRITE: cover property (@(posedge clk) disable iff (!rst_b)
        adv_wr ##1 reg_rd && reg_addr == ADDR_LOCAL_ADVERTISE);

endmodule : anab_regs

// ===== bench/anab_link_partner.sv
// remote station model: emits runs of received base-page bursts
// assumes one clock shared with the register bank; runs start on go
`timescale 1ns/1ps
module anab_link_partner (
    input wire logic clk, // core clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic go, // start a run, one-cycle pulse
    input wire logic [15:0] word, // code word for the whole run
    input wire logic [3:0] bursts, // bursts in the run
    input wire logic [3:0] gap, // idle cycles between bursts
    output logic burst_valid, // one-cycle burst pulse
    output logic [15:0] burst_word, // code word with burst_valid
    output logic busy // run in progress
);
    logic [15:0] held;
    logic [3:0] left;
    logic [3:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (!rst_b) begin
            burst_valid <= 1'b0;
            burst_word <= 16'hffff;
            busy <= 1'b0;
            left <= 4'h0;
            wait_cnt <= 4'h0;
            held <= 16'h0000;
        end else begin
            burst_valid <= 1'b0;
            // idle word keeps changing so a stale value is never trusted
            burst_word <= ~burst_word;
            if (go && !busy) begin
                held <= word;
                left <= bursts;
                wait_cnt <= 4'h0;
                busy <= 1'b1;
            end else if (busy) begin
                if (wait_cnt != 4'h0) begin
                    wait_cnt <= wait_cnt - 4'h1;
                end else if (left != 4'h0) begin
                    burst_valid <= 1'b1;
                    burst_word <= held;
                    left <= left - 4'h1;
                    wait_cnt <= gap;
                end else begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule : anab_link_partner

// ===== bench/anab_regs_tb_top.sv
// self-checking bench for the ability register bank
// assumes the bank's own assertions run inside it; partner feeds bursts
`timescale 1ns/1ps
module anab_regs_tb_top;
    import anab_pkg::*;

    logic clk, rst_b, duplex_strap_pin, reg_wr, reg_rd;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata, reg_rdata, burst_word, p_word;
    logic reg_rvalid, reg_hit, burst_valid, an_restart, an_complete;
    logic exp_read, pages_valid, page_received, strap_full_duplex;
    logic go, p_busy;
    logic [3:0] p_bursts, p_gap;
    anab_page_t local_page, partner_page;
    int failures = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////
    anab_regs dut (.clk(clk), .rst_b(rst_b),
        .duplex_strap_pin(duplex_strap_pin), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
        .burst_valid(burst_valid), .burst_word(burst_word),
        .an_restart(an_restart), .an_complete(an_complete),
        .exp_read(exp_read), .local_page(local_page),
        .partner_page(partner_page), .pages_valid(pages_valid),
        .page_received(page_received),
        .strap_full_duplex(strap_full_duplex));

    anab_link_partner partner (.clk(clk), .rst_b(rst_b), .go(go),
        .word(p_word), .bursts(p_bursts), .gap(p_gap),
        .burst_valid(burst_valid), .burst_word(burst_word), .busy(p_busy));

    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] exp,
                      input logic hit);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk1(reg_rvalid, 1'b1);
        chk1(reg_hit, hit);
        chk(reg_rdata, exp);
    endtask : rd

    // bounded wait: a stuck partner ends the run as a failure
    task automatic send(input logic [15:0] w, input logic [3:0] n,
                        input logic [3:0] g);
        int i;
        @(posedge clk);
        go <= 1'b1;
        p_word <= w;
        p_bursts <= n;
        p_gap <= g;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        for (i = 0; i < 200 && p_busy; i++) @(negedge clk);
        if (p_busy) begin
            failures++;
            end_of_test();
        end
    endtask : send

    task automatic pulse_exp_read;
        @(posedge clk);
        exp_read <= 1'b1;
        @(posedge clk);
        exp_read <= 1'b0;
        @(negedge clk);
    endtask : pulse_exp_read

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        duplex_strap_pin = 1'b1;
        {reg_wr, reg_rd, an_restart, an_complete, exp_read, go} = 6'h00;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        p_word = 16'h0000;
        p_bursts = 4'h0;
        p_gap = 4'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk1(strap_full_duplex, 1'b1);
        chk1(pages_valid, 1'b0);
        chk(partner_page, 16'h0000);
        rd(ADDR_LOCAL_ADVERTISE, 16'h01e1, 1'b1);
        rd(ADDR_PARTNER_BASE_PAGE, 16'h0000, 1'b1);
        wr(ADDR_LOCAL_ADVERTISE, 16'ha5e0);
        rd(ADDR_LOCAL_ADVERTISE, 16'ha5e1, 1'b1);
        // only the hardware-owned places get ones here
        wr(ADDR_LOCAL_ADVERTISE, 16'h421e);
        rd(ADDR_LOCAL_ADVERTISE, 16'h0001, 1'b1);
        wr(ADDR_PARTNER_BASE_PAGE, 16'hffff);
        rd(ADDR_PARTNER_BASE_PAGE, 16'h0000, 1'b1);
        rd(5'h06, 16'h0000, 1'b0);
        wr(ADDR_LOCAL_ADVERTISE, 16'h8400);
        an_complete <= 1'b1;
        send(16'hdbe1, 4'h2, 4'h0);
        chk1(local_page.ack, 1'b0);
        chk1(pages_valid, 1'b1);
        send(16'h1234, 4'h1, 4'h3);
        send(16'hdbe1, 4'h2, 4'h4);
        chk1(local_page.ack, 1'b0);
        chk(partner_page, 16'h0000);
        send(16'hdbe1, 4'h1, 4'h0);
        chk1(local_page.ack, 1'b1);
        chk(local_page, 16'hc401);
        chk(partner_page, 16'hdbe1);
        chk1(page_received, 1'b1);
        rd(ADDR_LOCAL_ADVERTISE, 16'hc401, 1'b1);
        rd(ADDR_PARTNER_BASE_PAGE, 16'hdbe1, 1'b1);
        pulse_exp_read();
        chk1(page_received, 1'b0);
        @(posedge clk);
        an_restart <= 1'b1;
        @(posedge clk);
        an_restart <= 1'b0;
        @(negedge clk);
        chk1(local_page.ack, 1'b0);
        chk(partner_page, 16'hdbe1);
        send(16'h2416, 4'h3, 4'h1);
        chk(partner_page, 16'h2416);
        chk1(page_received, 1'b1);
        rd(ADDR_PARTNER_BASE_PAGE, 16'h2416, 1'b1);
        // clearing read lands with the third burst: the set must win
        pulse_exp_read();
        chk1(page_received, 1'b0);
        @(posedge clk);
        an_restart <= 1'b1;
        @(posedge clk);
        an_restart <= 1'b0;
        go <= 1'b1;
        p_word <= 16'h0421;
        p_bursts <= 4'h3;
        p_gap <= 4'h0;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        exp_read <= 1'b1;
        @(posedge clk);
        exp_read <= 1'b0;
        @(negedge clk);
        chk1(page_received, 1'b1);
        chk(partner_page, 16'h0421);
        chk1(local_page.ack, 1'b1);
        // second reset with the strap low drops both full-duplex bits
        @(posedge clk);
        rst_b <= 1'b0;
        duplex_strap_pin <= 1'b0;
        an_complete <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk(partner_page, 16'h0000);
        chk1(page_received, 1'b0);
        rd(ADDR_LOCAL_ADVERTISE, 16'h00a1, 1'b1);
        chk1(strap_full_duplex, 1'b0);
        chk1(pages_valid, 1'b0);
        // third reset: a write before the strap load keeps bits 8 and 6
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wr(ADDR_LOCAL_ADVERTISE, 16'h0140);
        repeat (5) @(posedge clk);
        rd(ADDR_LOCAL_ADVERTISE, 16'h0141, 1'b1);
        end_of_test();
    end
endmodule : anab_regs_tb_top
